// *** rtl/fse_pkg.sv ***
// Purpose: shared constants and types for the flash self erase/write block
// Assumes: 32-bit AHB-Lite register words, 125 MHz core clock
// Notes: offsets are byte addresses
`default_nettype none
package fse_pkg;
    localparam logic [7:0] OFS_ADDR_LOW = 8'h00;
    localparam logic [7:0] OFS_ADDR_HIGH = 8'h04;
    localparam logic [7:0] OFS_DATA_LOW = 8'h08;
    localparam logic [7:0] OFS_DATA_HIGH = 8'h0C;
    localparam logic [7:0] OFS_CONTROL = 8'h10;
    localparam logic [7:0] OFS_UNLOCK = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    // control bit positions
    localparam int BIT_TRIGGER = 1;
    localparam int BIT_PERMIT = 2;
    localparam int BIT_ERROR = 3;
    localparam int BIT_ERASE = 4;
    localparam int BIT_SPACE = 7;
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;
    localparam logic [13:0] BUF_ERASED = 14'h3FFF;
    localparam int ROW_WORDS = 32;
    localparam int BLOCK_WORDS = 4;
    localparam int CLK_MHZ = 125;
    localparam int PROG_TIME_US = 2000;
    localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
    localparam int PWRT_TIME_US = 72000;
    localparam int PWRT_CYCLES = PWRT_TIME_US * CLK_MHZ;
    localparam int SETUP_CYCLES = 2;
    typedef enum logic [1:0] {
        KEY_IDLE = 2'b00,
        KEY_GOT1 = 2'b01,
        KEY_GOT2 = 2'b10
    } fse_key_type;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SETUP = 2'b01,
        ST_BUSY = 2'b10
    } fse_state_type;
    typedef struct packed {
        logic space;
        logic erase;
        logic permit;
        logic trigger;
        logic error;
    } fse_ctrl_type;
    typedef struct packed {
        logic erase;
        logic [12:0] addr;
        logic [4*14-1:0] data;
    } fse_flash_req_type;
endpackage
`default_nettype wire

// *** rtl/fse_flash_self_erase_write.sv ***
// Summary of operation
// - erase always clears a whole 32-word row
// - row picked by upper 8 address bits
// - start only after 55h, AAh, then trigger
// - two setup cycles after trigger for erase
// - core stalls about 2 ms, clocks keep running
// - write only where protect config allows
// - writes are aligned four-word blocks
// - four 14-bit buffers selected by address[1:0]
// - short write fills buffer, trigger clears
// - last word loads buffer and programs block
// - buffers return to 3FFF after long write
// - write permit cleared at power-up
// - no write during 72 ms power-up timer
// - trigger refused unless permit already set
// - started write completes despite permit clear
// - key and trigger needed for every operation
//
// Purpose: self erase/write sequencer for on-chip program flash
// Assumes: AHB-Lite slave, single word transfers, zero wait states
// Notes: flash array itself sits outside; o_flash_* drive it
//
// Our own choices: the AHB-Lite interface to the registers and the placing of the registers.
`default_nettype none
module fse_flash_self_erase_write #(
    parameter int PROG_CYC = fse_pkg::PROG_CYCLES,
    parameter int PWRT_CYC = fse_pkg::PWRT_CYCLES
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    input wire logic [1:0] i_write_protect_config,
    input wire logic [12:0] i_protect_limit,
    output logic o_core_stall,
    output logic o_skip_instr,
    output logic o_flash_start,
    output fse_pkg::fse_flash_req_type o_flash_req
);
    fse_pkg::fse_ctrl_type ctrl_r;
    fse_pkg::fse_key_type key_r;
    fse_pkg::fse_state_type state_r;
    logic [7:0] addr_low_r;
    logic [4:0] addr_high_r;
    logic [7:0] data_low_r;
    logic [5:0] data_high_r;
    logic [13:0] buf_r [fse_pkg::BLOCK_WORDS];
    logic [31:0] cnt_r;
    logic [31:0] pwrt_r;
    logic pwrt_done_r;
    logic long_r;
    logic wr_pend_r;
    logic [7:0] wr_ofs_r;
    logic [31:0] rdata_nxt;
    logic wr_now;
    logic [12:0] full_addr;
    logic allowed;
    logic go;
    logic is_long;

    assign wr_now = wr_pend_r;
    assign full_addr = {addr_high_r, addr_low_r};

    // protected region: config 00 none, else below a limit
    always_comb begin
        case (i_write_protect_config)
            2'b00: allowed = 1'b1;
            default: allowed = full_addr >= i_protect_limit;
        endcase
    end

    // trigger accepted only from the unlocked state with permit held
    assign go = wr_now && wr_ofs_r == fse_pkg::OFS_CONTROL
        && i_hwdata[fse_pkg::BIT_TRIGGER] && key_r == fse_pkg::KEY_GOT2
        && ctrl_r.permit && pwrt_done_r && state_r == fse_pkg::ST_IDLE;
    assign is_long = ctrl_r.erase || addr_low_r[1:0] == 2'b11;

    // address phase capture; writes land one cycle later
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_pend_r <= 1'b0;
            wr_ofs_r <= 8'h00;
        end else if (i_hready) begin
            wr_pend_r <= i_hsel && i_htrans[1] && i_hwrite;
            wr_ofs_r <= i_haddr[7:0];
        end
    end

    always_comb begin
        rdata_nxt = 32'h0000_0000;
        case (i_haddr[7:0])
            fse_pkg::OFS_ADDR_LOW: rdata_nxt[7:0] = addr_low_r;
            fse_pkg::OFS_ADDR_HIGH: rdata_nxt[4:0] = addr_high_r;
            fse_pkg::OFS_DATA_LOW: rdata_nxt[7:0] = data_low_r;
            fse_pkg::OFS_DATA_HIGH: rdata_nxt[5:0] = data_high_r;
            fse_pkg::OFS_CONTROL: begin
                rdata_nxt[fse_pkg::BIT_SPACE] = ctrl_r.space;
                rdata_nxt[fse_pkg::BIT_ERASE] = ctrl_r.erase;
                rdata_nxt[fse_pkg::BIT_ERROR] = ctrl_r.error;
                rdata_nxt[fse_pkg::BIT_PERMIT] = ctrl_r.permit;
                rdata_nxt[fse_pkg::BIT_TRIGGER] = ctrl_r.trigger;
            end
            fse_pkg::OFS_STATUS: begin
                rdata_nxt[0] = o_core_stall;
                rdata_nxt[1] = pwrt_done_r;
                rdata_nxt[3:2] = key_r;
            end
            default: rdata_nxt = 32'h0000_0000;
        endcase
    end

    // zero wait states: answer always ready and okay
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_hrdata <= 32'h0000_0000;
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end else begin
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
            if (i_hready && i_hsel && i_htrans[1] && !i_hwrite) begin
                o_hrdata <= rdata_nxt;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            addr_low_r <= 8'h00;
            addr_high_r <= 5'h00;
            data_low_r <= 8'h00;
            data_high_r <= 6'h00;
        end else if (wr_now) begin
            case (wr_ofs_r)
                fse_pkg::OFS_ADDR_LOW: addr_low_r <= i_hwdata[7:0];
                fse_pkg::OFS_ADDR_HIGH: addr_high_r <= i_hwdata[4:0];
                fse_pkg::OFS_DATA_LOW: data_low_r <= i_hwdata[7:0];
                fse_pkg::OFS_DATA_HIGH: data_high_r <= i_hwdata[5:0];
                default: ;
            endcase
        end
    end

    // unlock tracker; any other write drops back to idle
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            key_r <= fse_pkg::KEY_IDLE;
        end else if (wr_now) begin
            if (wr_ofs_r == fse_pkg::OFS_UNLOCK
                    && i_hwdata[7:0] == fse_pkg::KEY_FIRST) begin
                key_r <= fse_pkg::KEY_GOT1;
            end else if (wr_ofs_r == fse_pkg::OFS_UNLOCK
                    && i_hwdata[7:0] == fse_pkg::KEY_SECOND
                    && key_r == fse_pkg::KEY_GOT1) begin
                key_r <= fse_pkg::KEY_GOT2;
            end else begin
                key_r <= fse_pkg::KEY_IDLE;
            end
        end
    end

    // control register; permit cleared at reset
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_r <= '0;
        end else begin
            if (wr_now && wr_ofs_r == fse_pkg::OFS_CONTROL) begin
                ctrl_r.space <= i_hwdata[fse_pkg::BIT_SPACE];
                ctrl_r.erase <= i_hwdata[fse_pkg::BIT_ERASE];
                ctrl_r.permit <= i_hwdata[fse_pkg::BIT_PERMIT];
                if (!i_hwdata[fse_pkg::BIT_ERROR]) begin
                    ctrl_r.error <= 1'b0;
                end
            end
            if (go && !(ctrl_r.space && allowed)) begin
                ctrl_r.error <= 1'b1;
            end
            if (go && ctrl_r.space && allowed) begin
                ctrl_r.trigger <= 1'b1;
            end else if (state_r == fse_pkg::ST_IDLE) begin
                ctrl_r.trigger <= 1'b0;
            end else if (state_r == fse_pkg::ST_BUSY
                    && cnt_r == 32'd1) begin
                ctrl_r.trigger <= 1'b0;
            end
        end
    end

    // power-up timer gates every start
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pwrt_r <= 32'd0;
            pwrt_done_r <= 1'b0;
        end else if (!pwrt_done_r) begin
            pwrt_r <= pwrt_r + 32'd1;
            pwrt_done_r <= pwrt_r >= 32'(PWRT_CYC - 1);
        end
    end

    // sequencer; permit is not looked at once running
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r <= fse_pkg::ST_IDLE;
            cnt_r <= 32'd0;
            long_r <= 1'b0;
        end else begin
            case (state_r)
                fse_pkg::ST_IDLE: begin
                    if (go && ctrl_r.space && allowed && is_long) begin
                        state_r <= fse_pkg::ST_SETUP;
                        cnt_r <= 32'(fse_pkg::SETUP_CYCLES - 1);
                        long_r <= !ctrl_r.erase;
                    end
                end
                fse_pkg::ST_SETUP: begin
                    if (cnt_r == 32'd0) begin
                        state_r <= fse_pkg::ST_BUSY;
                        cnt_r <= 32'(PROG_CYC);
                    end else begin
                        cnt_r <= cnt_r - 32'd1;
                    end
                end
                fse_pkg::ST_BUSY: begin
                    if (cnt_r == 32'd1) begin
                        state_r <= fse_pkg::ST_IDLE;
                        cnt_r <= 32'd0;
                    end else begin
                        cnt_r <= cnt_r - 32'd1;
                    end
                end
                default: state_r <= fse_pkg::ST_IDLE;
            endcase
        end
    end

    // holding buffers, one per word of the block
    for (genvar g = 0; g < fse_pkg::BLOCK_WORDS; g++) begin : g_buf
        always_ff @(posedge i_mclk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                buf_r[g] <= fse_pkg::BUF_ERASED;
            end else if (go && ctrl_r.space && allowed && !ctrl_r.erase
                    && addr_low_r[1:0] == 2'(g)) begin
                buf_r[g] <= {data_high_r, data_low_r};
            end else if (state_r == fse_pkg::ST_BUSY && cnt_r == 32'd1
                    && long_r) begin
                buf_r[g] <= fse_pkg::BUF_ERASED;
            end
        end
    end

    // flash command outputs and core stall
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_core_stall <= 1'b0;
            o_skip_instr <= 1'b0;
            o_flash_start <= 1'b0;
            o_flash_req <= '0;
        end else begin
            o_skip_instr <= state_r == fse_pkg::ST_SETUP;
            o_core_stall <= state_r == fse_pkg::ST_BUSY
                && cnt_r != 32'd1;
            o_flash_start <= state_r == fse_pkg::ST_SETUP
                && cnt_r == 32'd0;
            if (state_r == fse_pkg::ST_SETUP && cnt_r == 32'd0) begin
                o_flash_req.erase <= !long_r;
                // erase: row by upper 8 bits; write: aligned block
                o_flash_req.addr <= long_r
                    ? {full_addr[12:2], 2'b00}
                    : {full_addr[12:5], 5'b00000};
                o_flash_req.data <= {buf_r[3], buf_r[2], buf_r[1], buf_r[0]};
            end
        end
    end
endmodule
`default_nettype wire

// *** verification/fse_checker_sva.sv ***
// Purpose: port checker for the flash self erase/write sequencer
// Assumes: one clock domain, async active-low reset
// Notes: stall length is counted in helper logic, not unrolled
`default_nettype none
module fse_checker #(
    parameter int PROG_CYC = 20
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic o_hreadyout,
    input wire logic o_hresp,
    input wire logic o_core_stall,
    input wire logic o_skip_instr,
    input wire logic o_flash_start,
    input wire fse_pkg::fse_flash_req_type o_flash_req
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_n);
    int stall_cnt_r;
    // cleared on every idle cycle so each stall is measured alone
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n)
            stall_cnt_r <= 0;
        else
            stall_cnt_r <= o_core_stall ? stall_cnt_r + 1 : 0;
    end
    AST_OKAY: assert property (o_hreadyout && !o_hresp)
        else $error("bus answer not ready or not okay");
    AST_START_PULSE: assert property (
        o_flash_start |=> !o_flash_start)
        else $error("flash start longer than one cycle");
    AST_SKIP_SEQ: assert property (
        $rose(o_skip_instr) |->
        ##1 (o_skip_instr && o_flash_start) ##1 !o_skip_instr)
        else $error("setup cycles not two before flash start");
    AST_STALL_AFTER: assert property (
        o_flash_start |=> o_core_stall && !o_skip_instr)
        else $error("no stall after flash start");
    AST_STALL_CAUSE: assert property (
        $rose(o_core_stall) |-> $past(o_flash_start))
        else $error("stall without flash start");
    AST_STALL_LEN: assert property (
        $fell(o_core_stall) |-> stall_cnt_r == PROG_CYC - 1)
        else $error("stall length wrong");
    AST_REQ_HELD: assert property (
        o_core_stall |-> $stable(o_flash_req))
        else $error("flash request changed during programming");
    AST_WRITE_ALIGN: assert property (
        o_flash_start && !o_flash_req.erase |->
        o_flash_req.addr[1:0] == 2'h0)
        else $error("block write not aligned");
    AST_ERASE_ROW: assert property (
        o_flash_start && o_flash_req.erase |->
        o_flash_req.addr[4:0] == 5'h00)
        else $error("erase row address keeps low bits");
    cover property (o_flash_start && o_flash_req.erase);
    cover property (o_flash_start && !o_flash_req.erase);
    cover property ($fell(o_core_stall));
endmodule
bind fse_flash_self_erase_write fse_checker #(.PROG_CYC(PROG_CYC)) u_chk (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .o_hreadyout(o_hreadyout),
    .o_hresp(o_hresp), .o_core_stall(o_core_stall),
    .o_skip_instr(o_skip_instr), .o_flash_start(o_flash_start),
    .o_flash_req(o_flash_req));
`default_nettype wire

// *** verification/testbench.sv ***
// Purpose: directed bench for the flash self erase/write sequencer
// Assumes: zero wait-state bus slave, short program and power-up counts
// Notes: flash starts are logged by a monitor and compared afterwards
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PROG = 20;
    localparam logic [31:0] TRIG = 32'h02;
    localparam logic [31:0] PRM = 32'h84;
    localparam logic [31:0] ERS = 32'h10;
    logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0] htrans = 2'h0, wp_cfg = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [12:0] wp_limit = 13'h0000;
    logic hready, hresp, stall, skip, start;
    logic [55:0] exp_data;
    logic [13:0] w;
    fse_pkg::fse_flash_req_type req, last_req;
    int num_errors = 0, checked = 0, n_start = 0;
    always #4 clk = ~clk;
    fse_flash_self_erase_write #(.PROG_CYC(PROG), .PWRT_CYC(40)) dut (
        .i_mclk(clk), .i_rst_n(rst_n), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
        .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
        .o_hreadyout(hready), .o_hresp(hresp),
        .i_write_protect_config(wp_cfg), .i_protect_limit(wp_limit),
        .o_core_stall(stall), .o_skip_instr(skip),
        .o_flash_start(start), .o_flash_req(req));
    always @(posedge clk) begin
        if (start === 1'b1) begin
            n_start++;
            last_req = req;
        end
    end
    task automatic check(input string what, input logic [69:0] seen,
                         input logic [69:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus(input logic wn, input logic [7:0] a,
                       input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wn;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdchk(string what, logic [7:0] a, logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(what, 70'(rd), 70'(exp));
    endtask
    // key and trigger back to back; nothing may split them
    task automatic op(input logic [31:0] ctl);
        wr(fse_pkg::OFS_UNLOCK, {24'h0, fse_pkg::KEY_FIRST});
        wr(fse_pkg::OFS_UNLOCK, {24'h0, fse_pkg::KEY_SECOND});
        wr(fse_pkg::OFS_CONTROL, ctl | TRIG);
    endtask
    task automatic load(logic [4:0] hi, logic [7:0] lo, logic [13:0] wd);
        wr(fse_pkg::OFS_ADDR_HIGH, {27'h0, hi});
        wr(fse_pkg::OFS_ADDR_LOW, {24'h0, lo});
        wr(fse_pkg::OFS_DATA_LOW, {24'h0, wd[7:0]});
        wr(fse_pkg::OFS_DATA_HIGH, {26'h0, wd[13:8]});
    endtask
    task automatic settle;
        repeat (PROG + 10) @(posedge clk);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        give_verdict;
    end
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rdchk("ctl_reset", fse_pkg::OFS_CONTROL, 32'h0);
        wr(fse_pkg::OFS_CONTROL, PRM);
        op(PRM);
        settle;
        check("pwrt_block", 70'(n_start), 70'(0));
        wr(fse_pkg::OFS_CONTROL, 32'h80);
        op(PRM);
        settle;
        check("no_permit", 70'(n_start), 70'(0));
        wr(fse_pkg::OFS_CONTROL, PRM | TRIG);
        settle;
        check("no_key", 70'(n_start), 70'(0));
        wr(fse_pkg::OFS_UNLOCK, {24'h0, fse_pkg::KEY_FIRST});
        wr(fse_pkg::OFS_ADDR_LOW, 32'h0);
        wr(fse_pkg::OFS_UNLOCK, {24'h0, fse_pkg::KEY_SECOND});
        wr(fse_pkg::OFS_CONTROL, PRM | TRIG);
        settle;
        check("stray_key", 70'(n_start), 70'(0));
        $display("test refusals done");
        // erase the row that the block write below targets
        load(5'h01, 8'h5F, 14'h0000);
        // select bits must stand before the trigger write
        wr(fse_pkg::OFS_CONTROL, PRM | ERS);
        op(PRM | ERS);
        settle;
        check("erase_count", 70'(n_start), 70'(1));
        check("erase_row", 70'({last_req.erase, last_req.addr}),
              70'({1'b1, 13'h0140}));
        rdchk("ctl_erase", fse_pkg::OFS_CONTROL, PRM | ERS);
        $display("test erase done");
        wr(fse_pkg::OFS_CONTROL, PRM);
        for (int i = 0; i < 4; i++) begin
            w = 14'(14'h10C0 + i * 14'h0101);
            exp_data[i*14 +: 14] = w;
            load(5'h01, 8'(8'h40 + i), w);
            op(PRM);
            if (i < 3) begin
                repeat (2) @(posedge clk);
                check("short_write", 70'(n_start), 70'(1));
                rdchk("short_trig", fse_pkg::OFS_CONTROL, PRM);
            end
        end
        settle;
        check("block_count", 70'(n_start), 70'(2));
        check("block_req", 70'(last_req),
              {1'b0, 13'h0140, exp_data});
        $display("test block write done");
        load(5'h01, 8'h47, 14'h2AAA);
        op(PRM);
        wr(fse_pkg::OFS_CONTROL, 32'h80);
        settle;
        check("permit_drop", 70'(n_start), 70'(3));
        check("buf_refill", 70'(last_req),
              {1'b0, 13'h0144, 14'h2AAA, {3{14'h3FFF}}});
        wp_cfg <= 2'h1;
        wp_limit <= 13'h0200;
        wr(fse_pkg::OFS_CONTROL, PRM);
        load(5'h01, 8'h03, 14'h0000);
        op(PRM);
        settle;
        check("protected", 70'(n_start), 70'(3));
        rdchk("ctl_error", fse_pkg::OFS_CONTROL, 32'h8C);
        rdchk("unlock_read", fse_pkg::OFS_UNLOCK, 32'h0);
        rdchk("unmapped", 8'h1C, 32'h0);
        $display("test protection done");
        give_verdict;
    end
endmodule
`default_nettype wire
